// ===== uhis_core.sv
// host attach detection, soft reset with oscillator restart, and the
// iso transfer versus frame marker scheduler
// assumes one 250 MHz clock; bus lines and reset pin are asynchronous
`timescale 1ns/1ps
`include "uhis_regs.svh"
//
// Operation
// - soft reset acts like external reset pin
// - reset clears host role select
// - oscillator off in reset; stable after settle
// - attach change flag set; write-one clears
// - detach: J/K then 25us SE0
// - attach: 8 SE0 bits then 25us J/K
// - enable gates attach flag onto interrupt
// - line status refreshed on sample or flag
// - defer: late 256-byte iso held to frame
// - out under-run writes code 0x06
// - in over-run writes code 0x06
// - no defer: out cut, marker, code 0x03
// - defer late out: marker, then done 0x00
// - tx buffer free stays low when out deferred
// - no defer: in runs on, marker suppressed
// - frame counter increments every frame
// - defer late in: marker, then in, 0x00
// - host makes marker every 1ms frame, except while an in runs on
// - frame flag on each marker; write-one clears
module uhis_core #(
    parameter int FRAME_CYC = `UHIS_FRAME_CYC,
    parameter int CONN_CYC  = `UHIS_CONN_CYC,
    parameter int SETTLE    = `UHIS_OSC_SETTLE_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       ext_reset_n_i,
    input  wire logic       soft_device_reset_i,
    input  wire logic       host_select_wr_i,
    input  wire logic       host_select_i,
    input  wire logic       dplus_pulldown_en_i,
    input  wire logic       dminus_pulldown_en_i,
    input  wire logic       attach_change_enable_i,
    input  wire logic       attach_change_clr_i,
    input  wire logic       frame_marker_clr_i,
    input  wire logic       transfer_done_clr_i,
    input  wire logic       line_sample_cmd_i,
    input  wire logic       iso_defer_select_i,
    input  wire logic       launch_wr_i,
    input  wire logic [7:0] transfer_launch_reg_i,
    input  wire logic       tx_data_ready_i,
    input  wire logic       rx_fifo_free_i,
    input  wire logic       pkt_end_i,
    input  wire logic       dplus_i,
    input  wire logic       dminus_i,
    output logic            osc_run_o,
    output logic            osc_stable_flag_o,
    output logic            host_mode_o,
    output logic            dplus_pulldown_o,
    output logic            dminus_pulldown_o,
    output logic            attach_change_flag_o,
    output logic            int_o,
    output logic            j_state_seen_o,
    output logic            k_state_seen_o,
    output logic            frame_marker_flag_o,
    output logic            marker_send_o,
    output logic [10:0]     frame_count_o,
    output logic            transfer_done_flag_o,
    output logic            tx_buffer_free_flag_o,
    output logic [3:0]      transfer_result_code_o,
    output logic            tok_send_o,
    output logic [3:0]      tok_ep_o,
    output logic            tok_in_o
);
    logic [2:0] pin_s;
    logic       rst_pin_n;
    logic [1:0] ln;
    logic       chip_rst;

    uhis_sync #(.W(3)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .d_i       ({ext_reset_n_i, dminus_i, dplus_i}),
        .q_o       (pin_s)
    );
    assign rst_pin_n = pin_s[2];
    assign ln        = {pin_s[1], pin_s[0]};
    assign chip_rst  = !rst_n_i || !rst_pin_n || soft_device_reset_i;

    // oscillator and settle
    logic [15:0] osc_cnt_q, osc_cnt_d;
    logic        osc_run_d, osc_ok_d;
    always_comb begin
        osc_run_d = !soft_device_reset_i;
        osc_cnt_d = osc_cnt_q;
        osc_ok_d  = osc_stable_flag_o;
        if (soft_device_reset_i) begin
            osc_cnt_d = '0;
            osc_ok_d  = 1'b0;
        end else if (osc_cnt_q < 16'(SETTLE)) begin
            osc_cnt_d = osc_cnt_q + 16'h1;
        end else begin
            osc_ok_d  = 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !rst_pin_n) begin
            osc_cnt_q         <= '0;
            osc_run_o         <= 1'b0;
            osc_stable_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            osc_cnt_q         <= osc_cnt_d;
            osc_run_o         <= osc_run_d;
            osc_stable_flag_o <= osc_ok_d;
        end
    end

    // configuration
    logic host_d, dpp_d, dmp_d;
    always_comb begin
        host_d = host_select_wr_i ? host_select_i : host_mode_o;
        dpp_d  = dplus_pulldown_en_i;
        dmp_d  = dminus_pulldown_en_i;
    end
    always_ff @(posedge sys_clk_i) begin
        if (chip_rst) begin
            host_mode_o       <= 1'b0;
            dplus_pulldown_o  <= 1'b0;
            dminus_pulldown_o <= 1'b0;
        end else if (clk_en_i) begin
            host_mode_o       <= host_d;
            dplus_pulldown_o  <= dpp_d;
            dminus_pulldown_o <= dmp_d;
        end
    end

    // attach and detach detector
    logic [17:0] lcnt_q, lcnt_d;
    logic        conn_q, conn_d, armed_q, armed_d, se0_q;
    logic        acf_d, jst_d, kst_d, int_d, ev;
    logic        is_se0;
    always_comb begin
        is_se0  = (ln == uhis_pkg::UHIS_LN_SE0);
        lcnt_d  = lcnt_q;
        conn_d  = conn_q;
        armed_d = armed_q;
        ev      = 1'b0;
        if (is_se0 != se0_q)
            lcnt_d = 18'h1;
        else if (lcnt_q != 18'h3ffff)
            lcnt_d = lcnt_q + 18'h1;
        if (!conn_q && is_se0 && lcnt_q >= 18'(`UHIS_SE0_CYC))
            armed_d = 1'b1;
        if (host_mode_o && lcnt_q >= 18'(CONN_CYC) && is_se0 == se0_q &&
            (conn_q ? is_se0 : (!is_se0 && armed_q))) begin
            conn_d  = !conn_q;
            armed_d = 1'b0;
            ev      = 1'b1;
        end
        acf_d = ev || (attach_change_flag_o && !attach_change_clr_i);
        jst_d = j_state_seen_o;
        kst_d = k_state_seen_o;
        if (line_sample_cmd_i || ev) begin
            jst_d = (ln == uhis_pkg::UHIS_LN_J);
            kst_d = (ln == uhis_pkg::UHIS_LN_K);
        end
        int_d = acf_d && attach_change_enable_i;
    end
    always_ff @(posedge sys_clk_i) begin
        if (chip_rst) begin
            lcnt_q               <= '0;
            conn_q               <= 1'b0;
            armed_q              <= 1'b0;
            se0_q                <= 1'b1;
            attach_change_flag_o <= 1'b0;
            j_state_seen_o       <= 1'b0;
            k_state_seen_o       <= 1'b0;
            int_o                <= 1'b0;
        end else if (clk_en_i) begin
            lcnt_q               <= lcnt_d;
            conn_q               <= conn_d;
            armed_q              <= armed_d;
            se0_q                <= is_se0;
            attach_change_flag_o <= acf_d;
            j_state_seen_o       <= jst_d;
            k_state_seen_o       <= kst_d;
            int_o                <= int_d;
        end
    end

    // frame timer and iso scheduler
    uhis_pkg::uhis_xfer_t st_q, st_d;
    logic [17:0] fcnt_q, fcnt_d;
    logic        fdue, late, hin_q, hin_d, mk_d, ff_d, dn_d, tb_d, tk_d;
    logic [3:0]  ep_q, ep_d, rc_d;
    logic [10:0] fc_d;
    localparam int LATE_AT = (FRAME_CYC > `UHIS_WIN_CYC) ?
        FRAME_CYC - `UHIS_WIN_CYC : 0;
    always_comb begin
        fdue  = host_mode_o && (fcnt_q == 18'(FRAME_CYC - 1));
        late  = fcnt_q >= 18'(LATE_AT);
        fcnt_d = fdue ? 18'h0 : (host_mode_o ? fcnt_q + 18'h1 : 18'h0);
        fc_d  = fdue ? frame_count_o + 11'h1 : frame_count_o;
        mk_d  = fdue;
        st_d  = st_q;
        hin_d = hin_q;
        ep_d  = ep_q;
        rc_d  = transfer_result_code_o;
        dn_d  = transfer_done_flag_o && !transfer_done_clr_i;
        tb_d  = tx_buffer_free_flag_o;
        tk_d  = 1'b0;
        case (st_q)
            uhis_pkg::UHIS_IDLE: begin
                tb_d = 1'b1;
                if (launch_wr_i && host_mode_o &&
                    (transfer_launch_reg_i[7:4] == `UHIS_LAUNCH_IN ||
                     transfer_launch_reg_i[7:4] == `UHIS_LAUNCH_OUT)) begin
                    hin_d = (transfer_launch_reg_i[7:4] == `UHIS_LAUNCH_IN);
                    ep_d  = transfer_launch_reg_i[3:0];
                    tb_d  = hin_d;
                    if (iso_defer_select_i && late) begin
                        st_d = uhis_pkg::UHIS_HOLD;
                    end else begin
                        st_d = hin_d ? uhis_pkg::UHIS_IN : uhis_pkg::UHIS_OUT;
                        tk_d = 1'b1;
                    end
                end
            end
            uhis_pkg::UHIS_HOLD: begin
                tb_d = hin_q;
                if (fdue) begin
                    st_d = hin_q ? uhis_pkg::UHIS_IN : uhis_pkg::UHIS_OUT;
                    tk_d = 1'b1;
                end
            end
            uhis_pkg::UHIS_OUT: begin
                if (fdue) begin
                    rc_d = `UHIS_RES_TRUNC;
                    st_d = uhis_pkg::UHIS_IDLE;
                end else if (!tx_data_ready_i) begin
                    rc_d = `UHIS_RES_RUN;
                    dn_d = 1'b1;
                    st_d = uhis_pkg::UHIS_IDLE;
                end else if (pkt_end_i) begin
                    rc_d = `UHIS_RES_OK;
                    dn_d = 1'b1;
                    st_d = uhis_pkg::UHIS_IDLE;
                end
            end
            uhis_pkg::UHIS_IN: begin
                if (fdue) begin
                    mk_d = 1'b0;
                    rc_d = `UHIS_RES_TRUNC;
                    hin_d = 1'b0;
                end
                if (!rx_fifo_free_i) begin
                    rc_d = `UHIS_RES_RUN;
                    dn_d = 1'b1;
                    st_d = uhis_pkg::UHIS_IDLE;
                end else if (pkt_end_i) begin
                    if (hin_q && !fdue) begin
                        rc_d = `UHIS_RES_OK;
                        dn_d = 1'b1;
                    end
                    st_d = uhis_pkg::UHIS_IDLE;
                end
            end
            default: st_d = uhis_pkg::UHIS_IDLE;
        endcase
        ff_d = fdue || (frame_marker_flag_o && !frame_marker_clr_i);
    end
    always_ff @(posedge sys_clk_i) begin
        if (chip_rst) begin
            st_q                   <= uhis_pkg::UHIS_IDLE;
            fcnt_q                 <= '0;
            hin_q                  <= 1'b0;
            ep_q                   <= '0;
            frame_count_o          <= '0;
            marker_send_o          <= 1'b0;
            frame_marker_flag_o    <= 1'b0;
            transfer_done_flag_o   <= 1'b0;
            tx_buffer_free_flag_o  <= 1'b1;
            transfer_result_code_o <= `UHIS_RES_OK;
            tok_send_o             <= 1'b0;
            tok_ep_o               <= '0;
            tok_in_o               <= 1'b0;
        end else if (clk_en_i) begin
            st_q                   <= st_d;
            fcnt_q                 <= fcnt_d;
            hin_q                  <= hin_d;
            ep_q                   <= ep_d;
            frame_count_o          <= fc_d;
            marker_send_o          <= mk_d;
            frame_marker_flag_o    <= ff_d;
            transfer_done_flag_o   <= dn_d;
            tx_buffer_free_flag_o  <= tb_d;
            transfer_result_code_o <= rc_d;
            tok_send_o             <= tk_d;
            tok_ep_o               <= ep_d;
            tok_in_o               <= hin_d;
        end
    end
endmodule // uhis_core

// ===== uhis_core_assertions.sv
// checker for the ports of uhis_core
// assumes a bind to uhis_core with its parameters handed on
`timescale 1ns/1ps
`include "uhis_regs.svh"
module uhis_core_assertions #(
    parameter int FRAME_CYC = 250000,
    parameter int CONN_CYC  = 6250,
    parameter int SETTLE    = 1024
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        soft_device_reset_i,
    input wire logic        attach_change_enable_i,
    input wire logic        attach_change_clr_i,
    input wire logic        iso_defer_select_i,
    input wire logic        launch_wr_i,
    input wire logic [7:0]  transfer_launch_reg_i,
    input wire logic        osc_run_o,
    input wire logic        osc_stable_flag_o,
    input wire logic        host_mode_o,
    input wire logic        attach_change_flag_o,
    input wire logic        int_o,
    input wire logic        frame_marker_flag_o,
    input wire logic        marker_send_o,
    input wire logic [10:0] frame_count_o,
    input wire logic        tx_buffer_free_flag_o,
    input wire logic [3:0]  transfer_result_code_o,
    input wire logic        tok_send_o,
    input wire logic [3:0]  tok_ep_o,
    input wire logic        tok_in_o
);
    localparam bit ALL_LATE = FRAME_CYC <= `UHIS_WIN_CYC;
    logic [2:0]  quiet_q, quiet_d;
    logic [10:0] fc_q;
    logic [7:0]  lreg_q;
    logic        seen_q, seen_d, step;
    int          gap_q, gap_d;
    always_comb begin
        quiet_d = soft_device_reset_i ? 3'h0 : quiet_q + {2'h0, ~&quiet_q};
        step    = frame_count_o == fc_q + 11'h1;
        gap_d   = step ? 1 : gap_q + 1;
        seen_d  = host_mode_o & (seen_q | step);
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            quiet_q <= 3'h0;
            seen_q  <= 1'b0;
            gap_q   <= 0;
        end else begin
            quiet_q <= quiet_d;
            seen_q  <= seen_d;
            gap_q   <= gap_d;
        end
        fc_q   <= frame_count_o;
        lreg_q <= transfer_launch_reg_i;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i || quiet_q != 3'h7);
    a_reset_clears: assert property (disable iff (!rst_n_i)
        soft_device_reset_i |-> ##[1:3] (!host_mode_o && !osc_run_o
        && !osc_stable_flag_o && !attach_change_flag_o))
        else $error("soft reset left state");
    a_osc_settle: assert property (disable iff (!rst_n_i)
        $fell(soft_device_reset_i) |-> !osc_stable_flag_o [*8]
        ##[1:6] osc_stable_flag_o) else $error("osc stable timing");
    a_int_follow: assert property (int_o ==
        (attach_change_flag_o & $past(attach_change_enable_i)))
        else $error("interrupt pin wrong");
    a_attach_hold: assert property (attach_change_flag_o
        && !attach_change_clr_i |=> attach_change_flag_o)
        else $error("attach flag dropped");
    a_frame_period: assert property (step && seen_q
        |-> gap_q == FRAME_CYC) else $error("frame period wrong");
    a_marker_flag: assert property (marker_send_o
        |-> ##[0:1] frame_marker_flag_o) else $error("no frame flag");
    a_token_code: assert property (tok_send_o && !marker_send_o
        |-> $past(launch_wr_i) && tok_ep_o == lreg_q[3:0]
        && tok_in_o == (lreg_q[7:4] == 4'h4)) else $error("token wrong");
    a_defer_pair: assert property (ALL_LATE && tok_send_o
        && iso_defer_select_i |-> marker_send_o)
        else $error("late token not held");
    a_out_commit: assert property (tok_send_o && !tok_in_o
        |-> !tx_buffer_free_flag_o) else $error("tx buffer free");
    c_deferred: cover property (tok_send_o && marker_send_o);
    c_truncated: cover property (transfer_result_code_o == 4'h3);
    c_attach: cover property ($rose(attach_change_flag_o));
endmodule // uhis_core_assertions

// ===== uhis_pkg.sv
// types shared by the iso scheduler and attach detector
package uhis_pkg;
    typedef enum logic [2:0] {
        UHIS_IDLE  = 3'b000,
        UHIS_HOLD  = 3'b001,
        UHIS_OUT   = 3'b010,
        UHIS_IN    = 3'b011
    } uhis_xfer_t;
    typedef enum logic [1:0] {
        UHIS_LN_SE0 = 2'b00,
        UHIS_LN_J   = 2'b01,
        UHIS_LN_K   = 2'b10,
        UHIS_LN_SE1 = 2'b11
    } uhis_line_t;
endpackage

// ===== uhis_regs.svh
// timing counts, reset values and codes for the iso scheduler and attach
// detector; assumes a 250 MHz system clock
`ifndef UHIS_REGS_SVH
`define UHIS_REGS_SVH
`define UHIS_CLK_MHZ        250
`define UHIS_CONN_US        25
`define UHIS_CONN_CYC       (`UHIS_CONN_US * `UHIS_CLK_MHZ)
`define UHIS_FRAME_US       1000
`define UHIS_FRAME_CYC      (`UHIS_FRAME_US * `UHIS_CLK_MHZ)
`define UHIS_FS_BIT_NS      83
`define UHIS_BIT_CYC        ((`UHIS_FS_BIT_NS * `UHIS_CLK_MHZ) / 1000)
`define UHIS_SE0_BITS       8
`define UHIS_SE0_CYC        (`UHIS_SE0_BITS * `UHIS_BIT_CYC)
`define UHIS_ISO_WIN_BYTES  256
`define UHIS_WIN_CYC        (`UHIS_ISO_WIN_BYTES * 8 * `UHIS_BIT_CYC)
`define UHIS_OSC_SETTLE_CYC 1024
`define UHIS_RES_OK         4'h0
`define UHIS_RES_TRUNC      4'h3
`define UHIS_RES_RUN        4'h6
`define UHIS_LAUNCH_IN      4'h4
`define UHIS_LAUNCH_OUT     4'h6
`endif

// ===== uhis_sync.sv
// two-flop synchroniser for pin levels
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/1ps
module uhis_sync #(
    parameter int W = 2
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = clk_en_i ? d_i : s1_q;
        s2_d = clk_en_i ? s1_q : q_o;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            q_o  <= '0;
        end else begin
            s1_q <= s1_d;
            q_o  <= s2_d;
        end
    end
endmodule // uhis_sync

// ===== uhis_usb_peer.sv
// usb peripheral model: line levels and packet end after a set length
// assumes one-cycle token and marker pulses from the host core
`timescale 1ns/1ps
module uhis_usb_peer (
    input  wire logic        sys_clk_i,
    input  wire logic        plugged_i,
    input  wire logic        pd_i,
    input  wire logic        tok_send_i,
    input  wire logic        tok_in_i,
    input  wire logic        marker_i,
    input  wire logic [15:0] len_i,
    output logic             dplus_o,
    output logic             dminus_o,
    output logic             pkt_end_o
);
    int   left = 0;
    logic in_q = 1'b0;
    logic tog  = 1'b0;
    initial pkt_end_o = 1'b0;
    always @(posedge sys_clk_i) begin
        tog <= ~tog;
        pkt_end_o <= (left == 1);
        if (tok_send_i) begin
            left <= int'(len_i);
            in_q <= tok_in_i;
        end else if (marker_i && !in_q) begin
            left <= 0;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    // idle J when plugged, floating lines flip without pulldowns
    assign dplus_o  = plugged_i | (~pd_i & tog);
    assign dminus_o = ~plugged_i & ~pd_i & ~tog;
endmodule // uhis_usb_peer

// ===== usb_host_iso_sched_attach_detect_tb_top.sv
// self-checking bench for uhis_core with a usb peripheral model
// assumes core, package, header, peer and checker are compiled
`timescale 1ns/1ps
module usb_host_iso_sched_attach_detect_tb_top;
    localparam int FC = 3000;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
    logic ext_reset_n_i = 1'b1, soft_device_reset_i = 1'b0;
    logic host_select_wr_i = 1'b0, host_select_i = 1'b0;
    logic dplus_pulldown_en_i = 1'b0, dminus_pulldown_en_i = 1'b0;
    logic attach_change_enable_i = 1'b0, attach_change_clr_i = 1'b0;
    logic frame_marker_clr_i = 1'b0, transfer_done_clr_i = 1'b0;
    logic line_sample_cmd_i = 1'b0, iso_defer_select_i = 1'b0;
    logic launch_wr_i = 1'b0, tx_data_ready_i = 1'b1, rx_fifo_free_i = 1'b1;
    logic [7:0] transfer_launch_reg_i = 8'h00;
    logic pkt_end_i, dplus_i, dminus_i, osc_run_o, osc_stable_flag_o;
    logic host_mode_o, dplus_pulldown_o, dminus_pulldown_o, int_o;
    logic attach_change_flag_o, j_state_seen_o, k_state_seen_o;
    logic frame_marker_flag_o, marker_send_o, transfer_done_flag_o;
    logic tx_buffer_free_flag_o, tok_send_o, tok_in_o;
    logic [10:0] frame_count_o, f0;
    logic [3:0]  transfer_result_code_o, tok_ep_o, cs = 4'h0;
    logic [5:0]  notes[$], n;
    logic        plugged = 1'b0, ds = 1'b0, go = 1'b0;
    logic [15:0] len = 16'h0000;
    int          fails = 0, cmp_count = 0, seed = 27, mk = 0, m0;
    uhis_core #(.FRAME_CYC(FC), .CONN_CYC(50), .SETTLE(8)) DUT (.*);
    uhis_usb_peer peer (.sys_clk_i(sys_clk_i), .plugged_i(plugged),
        .pd_i(dplus_pulldown_o & dminus_pulldown_o), .tok_send_i(tok_send_o),
        .tok_in_i(tok_in_o), .marker_i(marker_send_o), .len_i(len),
        .dplus_o(dplus_i), .dminus_o(dminus_i), .pkt_end_o(pkt_end_i));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (marker_send_o === 1'b1) mk++;
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b1; i++) cyc(1);
        if (s !== 1'b1) begin
            chk(1'b0, "wait ran out");
            give_verdict();
        end
    endtask
    task automatic sync(input int off);
        wait_hi(marker_send_o, FC + 10);
        cyc(off);
    endtask
    task automatic xfer(input logic [3:0] op, input int ln,
                        input logic [5:0] note);
        len = 16'(ln);
        transfer_launch_reg_i = {op, 4'($random(seed))};
        notes.push_back(note);
        transfer_done_clr_i = 1'b1;
        frame_marker_clr_i = 1'b1;
        pulse(launch_wr_i);
        transfer_done_clr_i = 1'b0;
        frame_marker_clr_i = 1'b0;
        for (int i = 0; i < 2 * FC && notes.size() > 0; i++) cyc(1);
        if (notes.size() > 0) begin
            chk(1'b0, "no transfer result");
            give_verdict();
        end
    endtask
    initial begin
        wait (go);
        forever begin
            @(negedge sys_clk_i);
            if ((transfer_done_flag_o === 1'b1 && !ds)
                || transfer_result_code_o !== cs) begin
                cyc(8 + int'(len));
                if (notes.size() == 0) chk(1'b0, "result without launch");
                else begin
                    n = notes.pop_front();
                    chk(transfer_result_code_o === n[3:0] && (!n[5]
                        || transfer_done_flag_o === n[4]), "result");
                end
            end
            ds = transfer_done_flag_o;
            cs = transfer_result_code_o;
        end
    end
    initial begin
        cyc(8);
        rst_n_i = 1'b1;
        wait_hi(osc_stable_flag_o, 40);
        chk(host_mode_o === 1'b0, "role after reset");
        host_select_i = 1'b1;
        pulse(host_select_wr_i);
        dplus_pulldown_en_i = 1'b1;
        dminus_pulldown_en_i = 1'b1;
        cyc(250);
        pulse(attach_change_clr_i);
        plugged = 1'b1;
        wait_hi(attach_change_flag_o, 400);
        chk((j_state_seen_o ^ k_state_seen_o) === 1'b1, "attach");
        attach_change_enable_i = 1'b1;
        cyc(3);
        chk(int_o === 1'b1, "int enabled");
        pulse(attach_change_clr_i);
        cyc(2);
        chk(attach_change_flag_o === 1'b0, "flag cleared");
        attach_change_enable_i = 1'b0;
        plugged = 1'b0;
        wait_hi(attach_change_flag_o, 400);
        cyc(2);
        chk({j_state_seen_o, k_state_seen_o, int_o} === 3'h0, "detach");
        pulse(attach_change_clr_i);
        plugged = 1'b1;
        cyc(12);
        pulse(line_sample_cmd_i);
        cyc(3);
        chk((j_state_seen_o ^ k_state_seen_o) === 1'b1, "sampled");
        plugged = 1'b0;
        cyc(120);
        $display("test attach finished");
        ext_reset_n_i = 1'b0;
        cyc(4);
        chk({host_mode_o, osc_stable_flag_o} === 2'h0, "pin reset");
        ext_reset_n_i = 1'b1;
        wait_hi(osc_stable_flag_o, 40);
        pulse(host_select_wr_i);
        cyc(2);
        chk(host_mode_o === 1'b1, "host again");
        pulse(soft_device_reset_i);
        cyc(2);
        chk({host_mode_o, osc_stable_flag_o} === 2'h0, "soft");
        wait_hi(osc_stable_flag_o, 40);
        pulse(host_select_wr_i);
        go = 1'b1;
        $display("test soft reset finished");
        for (int k = 0; k < 2; k++) begin
            sync(20);
            xfer(k ? 4'h6 : 4'h4, 10 + $unsigned($random(seed)) % 40, 6'h30);
        end
        tx_data_ready_i = 1'b0;
        sync(20);
        xfer(4'h6, 30, 6'h06);
        tx_data_ready_i = 1'b1;
        sync(FC - 40);
        m0 = mk;
        xfer(4'h6, 100, 6'h23);
        chk(frame_marker_flag_o === 1'b1 && mk == m0 + 1, "cut out");
        rx_fifo_free_i = 1'b0;
        sync(20);
        xfer(4'h4, 30, 6'h06);
        rx_fifo_free_i = 1'b1;
        sync(FC - 40);
        {m0, f0} = {mk, frame_count_o};
        xfer(4'h4, 100, 6'h23);
        chk(frame_marker_flag_o === 1'b1 && mk == m0, "late in");
        chk(frame_count_o === f0 + 11'h1, "count");
        iso_defer_select_i = 1'b1;
        for (int k = 0; k < 2; k++) begin
            sync(100);
            fork
                xfer(k ? 4'h4 : 4'h6, 30, 6'h30);
                begin
                    cyc(2);
                    wait_hi(frame_marker_flag_o, FC + 10);
                    chk(k == 1 || tx_buffer_free_flag_o === 1'b0, "held");
                end
            join
            chk(frame_marker_flag_o === 1'b1, "marker first");
        end
        $display("test transfers finished");
        give_verdict();
    end
endmodule // usb_host_iso_sched_attach_detect_tb_top
bind uhis_core uhis_core_assertions #(.FRAME_CYC(FRAME_CYC),
    .CONN_CYC(CONN_CYC), .SETTLE(SETTLE)) u_chk (.*);
